// *** hw/tmc_regs.vh ***
`ifndef TMC_REGS_VH
`define TMC_REGS_VH

// ==========================================================
// Register byte addresses, one aligned 32-bit word each
// ==========================================================
`define TMC_ADDR_CTRL1     8'h00
`define TMC_ADDR_CTRL2     8'h04
`define TMC_ADDR_STATUS    8'h08
`define TMC_ADDR_CNT_HI    8'h0c
`define TMC_ADDR_CNT_LO    8'h10
`define TMC_ADDR_ALT_HI    8'h14
`define TMC_ADDR_ALT_LO    8'h18
`define TMC_ADDR_CAP1_HI   8'h1c
`define TMC_ADDR_CAP1_LO   8'h20
`define TMC_ADDR_CAP2_HI   8'h24
`define TMC_ADDR_CAP2_LO   8'h28

// ==========================================================
// First control register fields
// ==========================================================
`define TMC_C1_CAPTURE_IRQ_ENABLE        7
`define TMC_C1_OVERFLOW_IRQ_ENABLE        5
`define TMC_C1_IEDG1       1

// ==========================================================
// Second control register fields
// ==========================================================
`define TMC_C2_OPM         4
`define TMC_C2_PWM         5
`define TMC_C2_CS_HI       3
`define TMC_C2_CS_LO       2
`define TMC_C2_IEDG2       1
`define TMC_C2_EXT_CLOCK_EDGE_SELECT       0

// ==========================================================
// Status register fields
// ==========================================================
`define TMC_SR_ICF1        7
`define TMC_SR_ICF2        6
`define TMC_SR_TOF         5

// ==========================================================
// Clock select codes and divider masks
// ==========================================================
`define TMC_CS_DIV4        2'b00
`define TMC_CS_DIV2        2'b01
`define TMC_CS_DIV8        2'b10
`define TMC_CS_EXT         2'b11
`define TMC_MASK_DIV2      3'h1
`define TMC_MASK_DIV4      3'h3
`define TMC_MASK_DIV8      3'h7

// ==========================================================
// Reset values and bus answers
// ==========================================================
`define TMC_CNT_RELOAD     16'hfffc
`define TMC_CNT_TOP        16'hffff
`define TMC_CTRL_RST       8'h00
`define TMC_RESP_OKAY      2'b00
`define TMC_RESP_SLVERR    2'b10

`endif

// *** hw/tmc_timer.v ***
`timescale 1ns/1ps
`include "tmc_regs.vh"

module tmc_timer #(
  parameter ADDR_W       = 8,   // Byte address width of the slave
  parameter CAP1_BONDED  = 1,   // Capture pin one present
  parameter CAP2_BONDED  = 1,   // Capture pin two present
  parameter EXT_TIMER_CLOCK_PIN_BONDED = 1   // External clock pin present
) (
  // Clock, reset, enable
  input  wire              SYS_CLK_I,
  input  wire              RESET_N_I,
  input  wire              CLK_EN_I,
  // AXI4-Lite write address and data
  input  wire              AXI_AWVALID_I,
  output reg               AXI_AWREADY_O,
  input  wire [ADDR_W-1:0] AXI_AWADDR_I,
  input  wire              AXI_WVALID_I,
  output reg               AXI_WREADY_O,
  input  wire [31:0]       AXI_WDATA_I,
  input  wire [3:0]        AXI_WSTRB_I,
  // AXI4-Lite write response
  output reg               AXI_BVALID_O,
  input  wire              AXI_BREADY_I,
  output reg  [1:0]        AXI_BRESP_O,
  // AXI4-Lite read
  input  wire              AXI_ARVALID_I,
  output reg               AXI_ARREADY_O,
  input  wire [ADDR_W-1:0] AXI_ARADDR_I,
  output reg               AXI_RVALID_O,
  input  wire              AXI_RREADY_I,
  output reg  [31:0]       AXI_RDATA_O,
  output reg  [1:0]        AXI_RRESP_O,
  // Core state inputs
  input  wire              HALT_MODE_I,
  input  wire              IRQ_MASK_I,
  // Timer pins
  input  wire              EXT_TIMER_CLOCK_PIN_I,
  input  wire              CAPTURE_INPUT_PIN1_I,
  input  wire              CAPTURE_INPUT_PIN2_I,
  // Interrupt request
  output reg               TIMER_IRQ_O
);

  // ========================================================
  // State
  // ========================================================
  reg  [15:0] count;          // Free-running counter
  reg  [2:0]  presc;          // Prescaler divider
  reg  [7:0]  ctrl1;          // First control register
  reg  [7:0]  ctrl2;          // Second control register
  reg         overflow_flag;  // Sticky overflow
  reg  [1:0]  capture_flag;   // Sticky capture per channel
  reg         tof_armed;      // Status seen with overflow set
  reg  [1:0]  icf_armed;      // Status seen with capture set
  reg  [7:0]  lo_buf;         // Frozen count low byte
  reg         lo_frozen;      // Two-byte read under way
  reg  [15:0] cap1;           // Capture register one
  reg  [15:0] cap2;           // Capture register two
  reg  [1:0]  cap_inhibit;    // High byte read, low pending
  reg  [2:0]  sync1;          // First synchroniser stage
  reg  [2:0]  sync2;          // Second synchroniser stage
  reg  [2:0]  pin_last;       // Previous synchronised level
  // Write channel holding
  reg  [ADDR_W-1:0] aw_addr;  // Captured write address
  reg  [31:0]  w_data;        // Captured write data
  reg          w_lane0;       // Low byte lane enabled
  reg          aw_held;       // Address taken
  reg          w_held;        // Data taken

  // ========================================================
  // Decoded controls
  // ========================================================
  wire [1:0] clock_select = ctrl2[`TMC_C2_CS_HI:`TMC_C2_CS_LO];
  wire       ext_clock_edge_select = ctrl2[`TMC_C2_EXT_CLOCK_EDGE_SELECT];
  wire       one_pulse_mode = ctrl2[`TMC_C2_OPM];
  wire       pulse_width_mode = ctrl2[`TMC_C2_PWM];
  wire [1:0] capture_edge_select = {ctrl2[`TMC_C2_IEDG2],
                                    ctrl1[`TMC_C1_IEDG1]};
  wire       overflow_irq_enable = ctrl1[`TMC_C1_OVERFLOW_IRQ_ENABLE];
  wire       capture_irq_enable = ctrl1[`TMC_C1_CAPTURE_IRQ_ENABLE];

  // ========================================================
  // Pin inputs, unbonded pins tied high
  // ========================================================
  // Pins not bonded out look like a steady one
  wire [2:0] pin_raw = {
    (EXT_TIMER_CLOCK_PIN_BONDED != 0) ? EXT_TIMER_CLOCK_PIN_I : 1'b1,
    (CAP2_BONDED   != 0) ? CAPTURE_INPUT_PIN2_I  : 1'b1,
    (CAP1_BONDED   != 0) ? CAPTURE_INPUT_PIN1_I  : 1'b1};

  // Two-stage synchroniser plus edge history
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1    <= 3'h7;
      sync2    <= 3'h7;
      pin_last <= 3'h7;
    end else if (CLK_EN_I) begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      pin_last <= sync2;
    end
  end

  // Edge chosen by select bit: one is rising, zero falling
  wire [2:0] rise = sync2 & ~pin_last;
  wire [2:0] fall = ~sync2 & pin_last;
  wire       ext_edge = ext_clock_edge_select ? rise[2] : fall[2];
  wire [1:0] cap_edge;
  assign cap_edge[0] = capture_edge_select[0] ? rise[0] : fall[0];
  assign cap_edge[1] = capture_edge_select[1] ? rise[1] : fall[1];

  // ========================================================
  // Count tick selection
  // ========================================================
  reg [2:0] div_mask;         // Prescaler terminal pattern
  always @* begin
    case (clock_select)
      `TMC_CS_DIV2: div_mask = `TMC_MASK_DIV2;
      `TMC_CS_DIV8: div_mask = `TMC_MASK_DIV8;
      default:      div_mask = `TMC_MASK_DIV4;
    endcase
  end
  // One tick per clock edge; ext edges need two CPU clocks
  // of spacing or some will be merged away
  wire ext_mode = (clock_select == `TMC_CS_EXT);
  wire tick = ext_mode ? ext_edge
                       : ((presc & div_mask) == div_mask);
  wire run  = ~HALT_MODE_I;   // Wait mode leaves run high
  wire wrap = run & tick & (count == `TMC_CNT_TOP);

  // ========================================================
  // Bus decode
  // ========================================================
  wire ar_fire = AXI_ARVALID_I & AXI_ARREADY_O;
  wire wr_go   = aw_held & w_held & ~AXI_BVALID_O;
  wire wr_en   = wr_go & w_lane0;
  wire rd_cnt_hi  = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CNT_HI);
  wire rd_cnt_lo  = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CNT_LO);
  wire rd_alt_hi  = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_ALT_HI);
  wire rd_alt_lo  = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_ALT_LO);
  wire rd_status  = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_STATUS);
  wire rd_c1_hi   = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CAP1_HI);
  wire rd_c1_lo   = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CAP1_LO);
  wire rd_c2_hi   = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CAP2_HI);
  wire rd_c2_lo   = ar_fire & (AXI_ARADDR_I == `TMC_ADDR_CAP2_LO);
  wire wr_cnt_lo  = wr_en & (aw_addr == `TMC_ADDR_CNT_LO);
  wire wr_alt_lo  = wr_en & (aw_addr == `TMC_ADDR_ALT_LO);
  wire wr_c1_lo   = wr_en & (aw_addr == `TMC_ADDR_CAP1_LO);
  wire wr_c2_lo   = wr_en & (aw_addr == `TMC_ADDR_CAP2_LO);

  // ========================================================
  // Counter and prescaler
  // ========================================================
  // Halt freezes both; reset wake-up restarts at reload value
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count <= `TMC_CNT_RELOAD;
      presc <= 3'h0;
    end else if (CLK_EN_I) begin
      if (wr_cnt_lo | wr_alt_lo) begin
        count <= `TMC_CNT_RELOAD;
        presc <= 3'h0;
      end else if (run) begin
        presc <= presc + 3'h1;
        if (tick)
          count <= count + 16'h0001;
      end
    end
  end

  // ========================================================
  // Two-byte read buffer
  // ========================================================
  // Either counter's high read freezes the low byte once
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lo_buf    <= 8'h00;
      lo_frozen <= 1'b0;
    end else if (CLK_EN_I) begin
      if (rd_cnt_lo | rd_alt_lo) begin
        lo_frozen <= 1'b0;
      end else if ((rd_cnt_hi | rd_alt_hi) & ~lo_frozen) begin
        lo_buf    <= count[7:0];
        lo_frozen <= 1'b1;
      end
    end
  end

  // ========================================================
  // Capture channels
  // ========================================================
  // Channel one idles in one-pulse and pulse-width modes
  wire [1:0] cap_allow = {1'b1,
                          ~(one_pulse_mode | pulse_width_mode)};
  // Pin edges always reach here, whatever the port direction
  wire [1:0] cap_hit = cap_edge & cap_allow & ~cap_inhibit;

  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cap1        <= 16'h0000;
      cap2        <= 16'h0000;
      cap_inhibit <= 2'b00;
    end else if (CLK_EN_I) begin
      if (cap_hit[0])
        cap1 <= count;
      if (cap_hit[1])
        cap2 <= count;
      // High read blocks transfers until the low read
      if (rd_c1_lo)
        cap_inhibit[0] <= 1'b0;
      else if (rd_c1_hi)
        cap_inhibit[0] <= 1'b1;
      if (rd_c2_lo)
        cap_inhibit[1] <= 1'b0;
      else if (rd_c2_hi)
        cap_inhibit[1] <= 1'b1;
    end
  end

  // ========================================================
  // Flags and clear sequences
  // ========================================================
  // Alternate low accesses never touch the overflow flag
  wire tof_clr = tof_armed & (rd_cnt_lo | wr_cnt_lo);
  wire [1:0] icf_clr = icf_armed & {rd_c2_lo | wr_c2_lo,
                                    rd_c1_lo | wr_c1_lo};

  // A set in the clearing cycle wins, so no event is lost
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      overflow_flag <= 1'b0;
      capture_flag  <= 2'b00;
      tof_armed     <= 1'b0;
      icf_armed     <= 2'b00;
    end else if (CLK_EN_I) begin
      overflow_flag <= wrap | (overflow_flag & ~tof_clr);
      capture_flag  <= cap_hit | (capture_flag & ~icf_clr);
      // Status read arms the second step
      if (rd_status)
        tof_armed <= overflow_flag;
      else if (tof_clr)
        tof_armed <= 1'b0;
      if (rd_status)
        icf_armed <= capture_flag;
      else
        icf_armed <= icf_armed & ~icf_clr;
    end
  end

  // ========================================================
  // Interrupt request
  // ========================================================
  // Request stays pending while masked; flags are sticky
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      TIMER_IRQ_O <= 1'b0;
    else if (CLK_EN_I)
      TIMER_IRQ_O <= ~IRQ_MASK_I &
        ((overflow_irq_enable & overflow_flag) |
         (capture_irq_enable & (|capture_flag)));
  end

  // ========================================================
  // Read data selection
  // ========================================================
  reg [7:0] rd_byte;          // Byte answered for the read
  reg       rd_ok;            // Address is mapped
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (AXI_ARADDR_I)
      `TMC_ADDR_CTRL1:   rd_byte = ctrl1;
      `TMC_ADDR_CTRL2:   rd_byte = ctrl2;
      `TMC_ADDR_STATUS: begin
        rd_byte[`TMC_SR_ICF1] = capture_flag[0];
        rd_byte[`TMC_SR_ICF2] = capture_flag[1];
        rd_byte[`TMC_SR_TOF]  = overflow_flag;
      end
      `TMC_ADDR_CNT_HI,
      `TMC_ADDR_ALT_HI:  rd_byte = count[15:8];
      // Both counters share one low byte, frozen by a high read
      `TMC_ADDR_CNT_LO,
      `TMC_ADDR_ALT_LO:  rd_byte = lo_frozen ? lo_buf
                                             : count[7:0];
      `TMC_ADDR_CAP1_HI: rd_byte = cap1[15:8];
      `TMC_ADDR_CAP1_LO: rd_byte = cap1[7:0];
      `TMC_ADDR_CAP2_HI: rd_byte = cap2[15:8];
      `TMC_ADDR_CAP2_LO: rd_byte = cap2[7:0];
      default:           rd_ok   = 1'b0;
    endcase
  end

  // ========================================================
  // AXI4-Lite read channel
  // ========================================================
  // One read at a time; address ready drops while answering
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      AXI_ARREADY_O <= 1'b0;
      AXI_RVALID_O  <= 1'b0;
      AXI_RDATA_O   <= 32'h0000_0000;
      AXI_RRESP_O   <= `TMC_RESP_OKAY;
    end else if (CLK_EN_I) begin
      if (ar_fire) begin
        AXI_ARREADY_O <= 1'b0;
        AXI_RVALID_O  <= 1'b1;
        AXI_RDATA_O   <= {24'h000000, rd_byte};
        AXI_RRESP_O   <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (AXI_RVALID_O & AXI_RREADY_I) begin
        AXI_RVALID_O  <= 1'b0;
        AXI_ARREADY_O <= 1'b1;
      end else if (~AXI_RVALID_O) begin
        AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  // ========================================================
  // AXI4-Lite write channels
  // ========================================================
  // Address and data are taken in either order, then acted on
  wire aw_fire = AXI_AWVALID_I & AXI_AWREADY_O;
  wire w_fire  = AXI_WVALID_I & AXI_WREADY_O;
  wire wr_map  = (aw_addr == `TMC_ADDR_CTRL1)   |
                 (aw_addr == `TMC_ADDR_CTRL2)   |
                 (aw_addr == `TMC_ADDR_CNT_LO)  |
                 (aw_addr == `TMC_ADDR_ALT_LO)  |
                 (aw_addr == `TMC_ADDR_CAP1_LO) |
                 (aw_addr == `TMC_ADDR_CAP2_LO);

  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      AXI_AWREADY_O <= 1'b0;
      AXI_WREADY_O  <= 1'b0;
      AXI_BVALID_O  <= 1'b0;
      AXI_BRESP_O   <= `TMC_RESP_OKAY;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h0000_0000;
      w_lane0       <= 1'b0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      ctrl1         <= `TMC_CTRL_RST;
      ctrl2         <= `TMC_CTRL_RST;
    end else if (CLK_EN_I) begin
      AXI_AWREADY_O <= ~aw_held & ~aw_fire;
      AXI_WREADY_O  <= ~w_held & ~w_fire;
      if (aw_fire) begin
        aw_addr <= AXI_AWADDR_I;
        aw_held <= 1'b1;
      end
      if (w_fire) begin
        w_data  <= AXI_WDATA_I;
        w_lane0 <= AXI_WSTRB_I[0];
        w_held  <= 1'b1;
      end
      if (wr_go) begin
        // Read-only registers ignore data but still answer
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O  <= wr_map ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
        if (w_lane0 & (aw_addr == `TMC_ADDR_CTRL1))
          ctrl1 <= w_data[7:0];
        if (w_lane0 & (aw_addr == `TMC_ADDR_CTRL2))
          ctrl2 <= w_data[7:0];
      end else if (AXI_BVALID_O & AXI_BREADY_I) begin
        AXI_BVALID_O  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        AXI_AWREADY_O <= 1'b1;
        AXI_WREADY_O  <= 1'b1;
      end
    end
  end

endmodule

// *** dv/tmc_pins_model.sv ***
`timescale 1ns/1ps
module tmc_pins_model (
  // Bench clock
  input  wire logic clk_i,
  // Pins toward the timer, idle high like pulled-up inputs
  output logic      ext_clk_o = 1'b1,
  output logic      cap1_o    = 1'b1,
  output logic      cap2_o    = 1'b1
);
  // ==========================================
  // External clock source
  // ==========================================
  // Active edges kept seven clocks apart; low three clocks, high four
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    // Let the synchroniser settle before the bench looks
    repeat (4) @(posedge clk_i);
  endtask

  // ==========================================
  // Capture pins: one low pulse, both edges
  // ==========================================
  task automatic cap_pulse(input int ch);
    @(posedge clk_i);
    if (ch == 0) cap1_o <= 1'b0;
    else cap2_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    if (ch == 0) cap1_o <= 1'b1;
    else cap2_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

// *** dv/tmc_timer_asserts.sv ***
`timescale 1ns/1ps
module tmc_timer_asserts (
  // Clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_N_I,
  // Bus handshakes
  input wire logic        AXI_ARVALID_I,
  input wire logic        AXI_ARREADY_O,
  input wire logic        AXI_RVALID_O,
  input wire logic        AXI_RREADY_I,
  input wire logic [31:0] AXI_RDATA_O,
  input wire logic [1:0]  AXI_RRESP_O,
  input wire logic        AXI_AWVALID_I,
  input wire logic        AXI_AWREADY_O,
  input wire logic        AXI_WVALID_I,
  input wire logic        AXI_WREADY_O,
  input wire logic        AXI_BVALID_O,
  input wire logic        AXI_BREADY_I,
  // Interrupt path
  input wire logic        IRQ_MASK_I,
  input wire logic        TIMER_IRQ_O
);
  // ==========================================
  // One clock domain, reset disables all
  // ==========================================
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  AST_R_AFTER_AR: assert property (
    AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O)
    else $error("read answer not one cycle after address");
  AST_R_HOLD: assert property (AXI_RVALID_O && !AXI_RREADY_I
    |=> AXI_RVALID_O && $stable(AXI_RDATA_O))
    else $error("read answer dropped or changed while stalled");
  AST_AR_BLOCK: assert property (AXI_RVALID_O |-> !AXI_ARREADY_O)
    else $error("address ready while answer pending");
  AST_R_BYTE: assert property (
    AXI_RVALID_O |-> AXI_RDATA_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_ERR_ZERO: assert property (
    AXI_RVALID_O && AXI_RRESP_O == 2'b10 |-> AXI_RDATA_O == 32'h0)
    else $error("error answer carries data");
  AST_B_AFTER: assert property (AXI_AWVALID_I && AXI_AWREADY_O
    && AXI_WVALID_I && AXI_WREADY_O |-> ##2 AXI_BVALID_O)
    else $error("write answer late");
  AST_B_HOLD: assert property (AXI_BVALID_O && !AXI_BREADY_I
    |=> AXI_BVALID_O)
    else $error("write answer dropped while stalled");
  AST_B_BLOCK: assert property (
    AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O)
    else $error("write ready while answer pending");
  AST_IRQ_MASK: assert property (
    IRQ_MASK_I |=> !TIMER_IRQ_O)
    else $error("request raised while masked");
endmodule

bind tmc_timer tmc_timer_asserts u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
  .AXI_ARVALID_I(AXI_ARVALID_I), .AXI_ARREADY_O(AXI_ARREADY_O),
  .AXI_RVALID_O(AXI_RVALID_O), .AXI_RREADY_I(AXI_RREADY_I),
  .AXI_RDATA_O(AXI_RDATA_O), .AXI_RRESP_O(AXI_RRESP_O),
  .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O),
  .AXI_WVALID_I(AXI_WVALID_I), .AXI_WREADY_O(AXI_WREADY_O),
  .AXI_BVALID_O(AXI_BVALID_O), .AXI_BREADY_I(AXI_BREADY_I),
  .IRQ_MASK_I(IRQ_MASK_I), .TIMER_IRQ_O(TIMER_IRQ_O)
);

// *** dv/tmc_timer_tb.sv ***
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer_tb;
  // ==========================================
  // Stimulus and observation signals
  // ==========================================
  logic        clk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic        halt = 1'b1, mask = 1'b1;
  logic        cen  = 1'b1;             // Clock enable toward the timer
  logic [3:0]  stb  = 4'hf;             // Write lane strobes
  wire         awr, wrdy, bv, arr, rv, irq, ext, c1, c2;
  wire  [1:0]  br, rr;
  logic [1:0]  rsp, bsp;
  logic [15:0] v;
  logic [1:0]  cs [3] = '{2'b01, 2'b00, 2'b10}; // Divide by 2, 4, 8
  int          n_fail = 0, checks_done = 0, n;

  always #20 clk = ~clk;

  tmc_timer dut_u (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(cen),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_AWADDR_I(awa),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy), .AXI_WDATA_I(wd),
    .AXI_WSTRB_I(stb), .AXI_BVALID_O(bv), .AXI_BREADY_I(bry),
    .AXI_BRESP_O(br), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
    .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv), .AXI_RREADY_I(rry),
    .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr), .HALT_MODE_I(halt),
    .IRQ_MASK_I(mask), .EXT_TIMER_CLOCK_PIN_I(ext),
    .CAPTURE_INPUT_PIN1_I(c1), .CAPTURE_INPUT_PIN2_I(c2),
    .TIMER_IRQ_O(irq)
  );
  tmc_pins_model u_pins (.clk_i(clk), .ext_clk_o(ext), .cap1_o(c1),
                         .cap2_o(c2));

  // ==========================================
  // Checking, expectations, verdict
  // ==========================================
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Count after a reload plus a number of ticks
  function logic [15:0] exp_cnt(input int ticks);
    return 16'hfffc + ticks[15:0];
  endfunction
  task test_done;
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // Bus master: entered just after an edge
  // ==========================================
  task wr(input logic [7:0] a, input logic [31:0] x);
    bit da, dw;
    da = 0;
    dw = 0;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= x;
    bry <= 1'b1;
    while (!(da && dw)) begin
      @(posedge clk);
      if (awr && !da) begin
        awv <= 1'b0;
        da = 1;
      end
      if (wrdy && !dw) begin
        wv <= 1'b0;
        dw = 1;
      end
    end
    do @(posedge clk); while (!bv);
    bsp = br;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  // Ready held back one cycle to stall the answer
  task rd(input logic [7:0] a, output logic [31:0] x);
    arv <= 1'b1;
    ara <= a;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    @(posedge clk);
    rry <= 1'b1;
    do @(posedge clk); while (!rv);
    x = rdat;
    rsp = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask
  task rd16(input logic [7:0] a);
    rd(a, d);
    v[15:8] = d[7:0];
    rd(a + 8'h04, d);
    v[7:0] = d[7:0];
  endtask

  // Hang guard: whole run is far shorter
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  initial begin
    void'($urandom(32'h9348acf7));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Halted from reset: count sits at reload value
    rd(`TMC_ADDR_ALT_HI, d);
    chk(d, 32'hff);
    halt <= 1'b0;
    // Seven edges with the enable low must not count
    repeat (10) @(posedge clk);
    cen <= 1'b0;
    repeat (7) @(posedge clk);
    cen <= 1'b1;
    repeat (10) @(posedge clk);
    halt <= 1'b1;
    rd(`TMC_ADDR_CNT_HI, d);
    chk(d, 32'h00);
    rd(`TMC_ADDR_CNT_LO, d);
    chk(d, 32'hfc);
    rd(`TMC_ADDR_CNT_LO, d);
    chk(d, {24'h0, exp_cnt(5)});
    // Each prescaler code over 64 running clocks
    for (int i = 0; i < 3; i++) begin
      wr(`TMC_ADDR_CTRL2, {28'h0, cs[i], 2'b00});
      wr(i[0] ? `TMC_ADDR_ALT_LO : `TMC_ADDR_CNT_LO, $urandom);
      halt <= 1'b0;
      repeat (64) @(posedge clk);
      halt <= 1'b1;
      rd16(`TMC_ADDR_CNT_HI);
      chk(v, exp_cnt(64 >> (i + 1)));
    end
    // Overflow flag, request and clear order
    wr(`TMC_ADDR_CTRL1, 32'h20);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    mask <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[5], 1'b1);
    rd(`TMC_ADDR_ALT_LO, d);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[5], 1'b1);
    rd(`TMC_ADDR_CNT_LO, d);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[5], 1'b0);
    chk(irq, 1'b0);
    // External clock, rising edges, random count
    wr(`TMC_ADDR_CTRL1, 32'h82);
    wr(`TMC_ADDR_CTRL2, 32'h0d);
    wr(`TMC_ADDR_CNT_LO, $urandom);
    halt <= 1'b0;
    n = $urandom_range(8, 1);
    u_pins.ext_pulses(n);
    rd16(`TMC_ADDR_CNT_HI);
    chk(v, exp_cnt(n));
    // Channel one rising, channel two falling
    u_pins.cap_pulse(0);
    rd16(`TMC_ADDR_CAP1_HI);
    chk(v, exp_cnt(n));
    u_pins.ext_pulses(1);
    u_pins.cap_pulse(1);
    // Low read without a status read first keeps the flag
    rd16(`TMC_ADDR_CAP2_HI);
    chk(v, exp_cnt(n + 1));
    rd(`TMC_ADDR_STATUS, d);
    chk(d[7:6], 2'b11);
    chk(irq, 1'b1);
    // High read blocks a new capture until low read
    rd(`TMC_ADDR_CAP1_HI, d);
    u_pins.ext_pulses(1);
    u_pins.cap_pulse(0);
    rd(`TMC_ADDR_CAP1_LO, d);
    chk(d[7:0], exp_cnt(n) & 16'hff);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[7:6], 2'b01);
    rd(`TMC_ADDR_CAP2_LO, d);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[7:6], 2'b00);
    // One-pulse mode leaves only channel two
    wr(`TMC_ADDR_CTRL2, 32'h1d);
    u_pins.cap_pulse(0);
    u_pins.cap_pulse(1);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[7:6], 2'b01);
    // Pulse-width mode also leaves only channel two
    rd(`TMC_ADDR_CAP2_LO, d);
    wr(`TMC_ADDR_CTRL2, 32'h2d);
    u_pins.cap_pulse(0);
    u_pins.cap_pulse(1);
    rd(`TMC_ADDR_STATUS, d);
    chk(d[7:6], 2'b01);
    // Low lane strobe off: write answered but ignored
    stb <= 4'he;
    wr(`TMC_ADDR_CTRL1, 32'h0);
    stb <= 4'hf;
    chk(bsp, 2'b00);
    rd(`TMC_ADDR_CTRL1, d);
    chk(d, 32'h82);
    // Unmapped place answers with an error
    wr(8'h2c, $urandom);
    chk(bsp, 2'b10);
    rd(8'h2c, d);
    chk(rsp, 2'b10);
    test_done;
  end
endmodule
